// [logic/fbp_pkg.sv]
// Package for the flash block protection logic: geometry, protection modes, request carriers.
// Assumes a single system clock and a synchronous active-high reset in every user.
package fbp_pkg;

   localparam int unsigned FBP_FLASH_BYTES   = 98304;  // 96 KB
   localparam int unsigned FBP_BLOCK_BYTES   = 1024;   // Erase granularity
   localparam int unsigned FBP_UNIT_BYTES    = 2048;   // Protection granularity
   localparam int unsigned FBP_ADDR_W        = 17;
   localparam int unsigned FBP_WORD_W        = 32;
   localparam int unsigned FBP_WORD_OFS_W    = 2;
   localparam int unsigned FBP_BLOCK_OFS_W   = 10;
   localparam int unsigned FBP_UNIT_OFS_W    = 11;
   localparam int unsigned FBP_NUM_BLOCKS    = FBP_FLASH_BYTES / FBP_BLOCK_BYTES;
   localparam int unsigned FBP_NUM_UNITS     = FBP_FLASH_BYTES / FBP_UNIT_BYTES;
   localparam int unsigned FBP_WORDS         = FBP_FLASH_BYTES / 4;
   localparam int unsigned FBP_BLOCK_WORDS   = FBP_BLOCK_BYTES / 4;
   localparam int unsigned FBP_BLOCK_IDX_W   = 7;
   localparam int unsigned FBP_UNIT_IDX_W    = 6;
   localparam int unsigned FBP_WIDX_W        = 15;
   localparam int unsigned FBP_BWORD_W       = 8;

   localparam logic [31:0] FBP_ERASED_WORD   = 32'hFFFF_FFFF;
   localparam logic [7:0]  FBP_BWORD_LAST    = 8'hFF;

   typedef enum logic [1:0] {
      FBP_PROT_OPEN      = 2'h0,
      FBP_PROT_READ_ONLY = 2'h1,
      FBP_PROT_EXEC_ONLY = 2'h2
   } fbp_prot_t;

   localparam fbp_prot_t FBP_PROT_RESET = FBP_PROT_OPEN;

   typedef enum logic [2:0] {
      FBP_OP_FETCH   = 3'h0,
      FBP_OP_DREAD   = 3'h1,
      FBP_OP_DBGREAD = 3'h2,
      FBP_OP_PROGRAM = 3'h3,
      FBP_OP_ERASE   = 3'h4
   } fbp_op_t;

   typedef struct packed {
      fbp_op_t                  op;
      logic [FBP_ADDR_W-1:0]    addr;
      logic [FBP_WORD_W-1:0]    wdata;
   } fbp_req_t;

   typedef struct packed {
      logic                     ok;
      logic                     refused;
      logic [FBP_WORD_W-1:0]    rdata;
   } fbp_rsp_t;

   typedef enum logic [1:0] {
      FBP_ST_IDLE  = 2'b00,
      FBP_ST_ERASE = 2'b01,
      FBP_ST_DONE  = 2'b11
   } fbp_state_t;

endpackage

// [logic/fbp_checker_rules.sv]
// Permission decision for one request against the protection setting of its unit.
// Assumes the caller has already chosen the unit's setting from the request address.
`timescale 1ns/1ps
module fbp_permit (
   input  wire fbp_pkg::fbp_op_t   op,
   input  wire fbp_pkg::fbp_prot_t prot,
   output logic                    allow
);
   import fbp_pkg::*;

   always_comb begin
      case (prot)
         FBP_PROT_READ_ONLY: allow = (op == FBP_OP_FETCH) || (op == FBP_OP_DREAD)
                                     || (op == FBP_OP_DBGREAD);
         FBP_PROT_EXEC_ONLY: allow = (op == FBP_OP_FETCH);
         default:            allow = 1'b1;
      endcase
   end
endmodule // fbp_permit

// [logic/fbp_flash_protect.sv]
// Flash array with 1 KB erase blocks and 2 KB protection units.
// Assumes one request at a time, taken only while req_ready is high; protection is set by plain inputs.
//
// What this block does
// - Holds a 96 KB flash storage array.
// - Erases single 1 KB blocks independently.
// - Erased block reads all ones.
// - Protection applies per 2 KB block pair.
// - Units may be open, read-only, execute-only.
// - Read-only units refuse erase and program.
// - Execute-only units refuse erase and program.
// - Execute-only units answer instruction fetches only.
`timescale 1ns/1ps
module fbp_flash_protect #(
   parameter int unsigned NUM_UNITS = fbp_pkg::FBP_NUM_UNITS
) (
   input  wire logic                          clock,
   input  wire logic                          reset,
   input  wire logic                          req_valid,
   output logic                               req_ready,
   input  wire fbp_pkg::fbp_req_t             req,
   output logic                               rsp_valid,
   output fbp_pkg::fbp_rsp_t                  rsp,
   input  wire logic                          prot_we,
   input  wire logic [fbp_pkg::FBP_UNIT_IDX_W-1:0] prot_unit,
   input  wire fbp_pkg::fbp_prot_t            prot_value,
   output fbp_pkg::fbp_prot_t                 prot_read,
   output logic                               erase_busy
);
   import fbp_pkg::*;

   logic [FBP_WORD_W-1:0]     mem [FBP_WORDS];
   fbp_prot_t                 prot_reg [NUM_UNITS];
   fbp_prot_t                 prot_next [NUM_UNITS];
   fbp_state_t                state_reg, state_next;
   logic [FBP_BLOCK_IDX_W-1:0] eblk_reg, eblk_next;
   logic [FBP_BWORD_W-1:0]    ecnt_reg, ecnt_next;
   fbp_rsp_t                  rsp_reg, rsp_next;
   logic                      rspv_reg, rspv_next;
   logic [FBP_UNIT_IDX_W-1:0] unit_idx;
   logic [FBP_BLOCK_IDX_W-1:0] blk_idx;
   logic [FBP_WIDX_W-1:0]     word_idx;
   logic                      in_range;
   logic                      allow;
   logic                      take;
   logic                      mem_we;
   logic [FBP_WIDX_W-1:0]     mem_wa;
   logic [FBP_WORD_W-1:0]     mem_wd;

   // Offset bits within a unit or block are simply dropped
   assign unit_idx = req.addr[FBP_ADDR_W-1:FBP_UNIT_OFS_W];
   assign blk_idx  = req.addr[FBP_ADDR_W-1:FBP_BLOCK_OFS_W];
   assign word_idx = req.addr[FBP_ADDR_W-1:FBP_WORD_OFS_W];
   assign in_range = ({15'h0000, req.addr} < FBP_FLASH_BYTES);

   fbp_permit u_permit (
      .op    (req.op),
      .prot  (in_range ? prot_reg[unit_idx] : FBP_PROT_OPEN),
      .allow (allow)
   );

   // No new request while an erase sweeps its block, so reads never see half-erased data
   assign req_ready  = (state_reg == FBP_ST_IDLE);
   assign take       = req_valid && req_ready;
   assign erase_busy = (state_reg != FBP_ST_IDLE);
   assign prot_read  = prot_reg[prot_unit];
   assign rsp_valid  = rspv_reg;
   assign rsp        = rsp_reg;

   always_comb begin
      for (int i = 0; i < NUM_UNITS; i++) begin
         prot_next[i] = prot_reg[i];
      end
      if (prot_we && (prot_unit < FBP_UNIT_IDX_W'(NUM_UNITS))) begin
         prot_next[prot_unit] = prot_value;
      end
   end

   always_comb begin
      state_next = state_reg;
      eblk_next  = eblk_reg;
      ecnt_next  = ecnt_reg;
      rspv_next  = 1'b0;
      rsp_next   = rsp_reg;
      mem_we     = 1'b0;
      mem_wa     = word_idx;
      mem_wd     = req.wdata;
      case (state_reg)
         FBP_ST_IDLE: begin
            if (take) begin
               rsp_next.rdata   = '0;
               rsp_next.ok      = 1'b0;
               rsp_next.refused = 1'b1;
               if (in_range && allow) begin
                  case (req.op)
                     FBP_OP_PROGRAM: begin
                        // Programming only clears bits, as in real flash cells
                        mem_we       = 1'b1;
                        mem_wd       = mem[word_idx] & req.wdata;
                        rsp_next.ok      = 1'b1;
                        rsp_next.refused = 1'b0;
                        rspv_next    = 1'b1;
                     end
                     FBP_OP_ERASE: begin
                        eblk_next  = blk_idx;
                        ecnt_next  = '0;
                        state_next = FBP_ST_ERASE;
                     end
                     default: begin
                        rsp_next.rdata   = mem[word_idx];
                        rsp_next.ok      = 1'b1;
                        rsp_next.refused = 1'b0;
                        rspv_next    = 1'b1;
                     end
                  endcase
               end else begin
                  rspv_next = 1'b1;
               end
            end
         end
         FBP_ST_ERASE: begin
            mem_we = 1'b1;
            mem_wa = {eblk_reg, ecnt_reg};
            mem_wd = FBP_ERASED_WORD;
            ecnt_next = ecnt_reg + 8'h01;
            if (ecnt_reg == FBP_BWORD_LAST) begin
               state_next = FBP_ST_DONE;
            end
         end
         FBP_ST_DONE: begin
            rsp_next.ok      = 1'b1;
            rsp_next.refused = 1'b0;
            rsp_next.rdata   = '0;
            rspv_next        = 1'b1;
            state_next       = FBP_ST_IDLE;
         end
         default: state_next = FBP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= FBP_ST_IDLE;
         eblk_reg  <= '0;
         ecnt_reg  <= '0;
         rspv_reg  <= 1'b0;
         rsp_reg   <= '0;
         for (int i = 0; i < NUM_UNITS; i++) begin
            prot_reg[i] <= FBP_PROT_RESET;
         end
      end else begin
         state_reg <= state_next;
         eblk_reg  <= eblk_next;
         ecnt_reg  <= ecnt_next;
         rspv_reg  <= rspv_next;
         rsp_reg   <= rsp_next;
         for (int i = 0; i < NUM_UNITS; i++) begin
            prot_reg[i] <= prot_next[i];
         end
      end
   end

   // Array contents survive reset, as flash does
   always_ff @(posedge clock) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end
endmodule // fbp_flash_protect

// [bench/fbp_protect_properties.sv]
// Port assertions for the flash protection block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module fbp_protect_properties #(parameter int unsigned NUM_UNITS = fbp_pkg::FBP_NUM_UNITS) (
   input wire logic                              clock, reset, req_valid, req_ready, rsp_valid, prot_we, erase_busy,
   input wire fbp_pkg::fbp_req_t                 req,
   input wire fbp_pkg::fbp_rsp_t                 rsp,
   input wire logic [fbp_pkg::FBP_UNIT_IDX_W-1:0] prot_unit,
   input wire fbp_pkg::fbp_prot_t                prot_value, prot_read
);
   import fbp_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   wire take = req_valid && req_ready;
   wire mine = take && !prot_we && prot_unit == req.addr[16:11];
   wire wr = req.op inside {FBP_OP_PROGRAM, FBP_OP_ERASE};
   wire xo = prot_read == FBP_PROT_EXEC_ONLY;
   // Busy spans 256 write cycles plus the done cycle, then drops as the answer appears
   sequence s_sweep; ##256 erase_busy ##1 !erase_busy; endsequence
   a_read_answer: assert property (take && req.op != FBP_OP_ERASE |=> rsp_valid)
      else $error("late answer");
   a_range_refuse: assert property (take && req.addr > 17'h1_7FFF |=> rsp.refused && !rsp.ok)
      else $error("range");
   a_lock_write: assert property (mine && wr && prot_read != FBP_PROT_OPEN |=> rsp_valid && rsp.refused)
      else $error("write taken");
   a_exec_data: assert property (mine && xo && req.op inside {FBP_OP_DREAD, FBP_OP_DBGREAD} |=> rsp.refused)
      else $error("data read");
   a_exec_fetch: assert property (mine && xo && req.op == FBP_OP_FETCH |=> rsp.ok)
      else $error("fetch refused");
   a_erase_sweep: assert property ($rose(erase_busy) |-> s_sweep ##0 rsp_valid && rsp.ok)
      else $error("erase span");
   a_busy_stall: assert property (erase_busy |-> !req_ready && !rsp_valid)
      else $error("busy");
   a_prot_store: assert property (prot_we |=> prot_read == $past(prot_value) || $changed(prot_unit))
      else $error("setting");
endmodule // fbp_protect_properties
bind fbp_flash_protect fbp_protect_properties #(.NUM_UNITS(NUM_UNITS)) props_u (.*);

// [bench/fbp_host_model.sv]
// Requester model for the fetch and data buses and the debugger, sharing one channel.
// Assumes one caller at a time; drives on the falling edge and holds a request until taken.
`timescale 1ns/1ps
module fbp_host_model (
   input  wire logic         clock, req_ready, rsp_valid,
   output logic              req_valid = 1'b0,
   output fbp_pkg::fbp_req_t req = '0
);
   import fbp_pkg::*;
   task automatic xfer(input fbp_op_t op, input logic [FBP_ADDR_W-1:0] addr, input logic [FBP_WORD_W-1:0] wdata);
      int n;
      @(negedge clock);
      req_valid = 1'b1;
      req = '{op, addr, wdata};
      for (n = 0; n < 400 && req_ready !== 1'b1; n++)
         @(negedge clock);
      @(negedge clock);
      req_valid = 1'b0;
      // Released lines carry the inverse, so a stale request never looks right by luck
      req = fbp_req_t'(~req);
      for (n = 0; n < 300 && rsp_valid !== 1'b1; n++)
         @(negedge clock);
   endtask
endmodule // fbp_host_model

// [bench/flash_block_protection_bench.sv]
// Bench for the flash protection block: erase, program, protection modes, address range.
// Assumes the host model is the sole requester; inputs change on the falling edge.
`timescale 1ns/1ps
module flash_block_protection_bench;
   import fbp_pkg::*;
   localparam logic [33:0] REF = 34'h1_0000_0000;
   localparam logic [33:0] OK_ONES = {2'b10, FBP_ERASED_WORD};
   localparam logic [33:0] OK_PAT = 34'h2_1234_5678;
   logic clock = 1'b0, reset = 1'b1, prot_we = 1'b0, req_valid, req_ready, rsp_valid, erase_busy;
   logic [FBP_UNIT_IDX_W-1:0] prot_unit = 6'h01;
   fbp_req_t req;
   fbp_rsp_t rsp;
   fbp_prot_t prot_value = FBP_PROT_OPEN, prot_read;
   int err_count = 0, comparisons = 0;
   fbp_flash_protect dut_u (.*);
   fbp_host_model host_u (.*);
   initial forever #5 clock = ~clock;
   task automatic report_and_stop;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [34:0] seen, input logic [34:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Accepted write answers carry no data, so only their status bits are judged
   task automatic xchk(input fbp_op_t op, input logic [16:0] a, input logic [33:0] exp);
      host_u.xfer(op, a, exp[31:0]);
      chk(op.name(), {rsp_valid, rsp[33:32], (exp[32] || op < FBP_OP_PROGRAM) ? rsp.rdata : exp[31:0]}, {1'b1, exp});
   endtask
   task automatic set_prot(input fbp_prot_t v);
      @(negedge clock);
      prot_we = 1'b1;
      prot_value = v;
      @(negedge clock);
      prot_we = 1'b0;
      chk("prot_read", 35'(prot_read), 35'(v));
   endtask
   task automatic erase_and_program;
      xchk(FBP_OP_ERASE, 17'h0_0800, OK_ONES);
      xchk(FBP_OP_DREAD, 17'h0_0BFC, OK_ONES);
      xchk(FBP_OP_PROGRAM, 17'h0_0800, OK_PAT);
      xchk(FBP_OP_ERASE, 17'h0_0C00, OK_ONES);
      xchk(FBP_OP_FETCH, 17'h0_0800, OK_PAT);
      xchk(FBP_OP_DBGREAD, 17'h1_8000, REF);
   endtask
   task automatic read_only_unit;
      set_prot(FBP_PROT_READ_ONLY);
      xchk(FBP_OP_PROGRAM, 17'h0_0800, REF);
      xchk(FBP_OP_ERASE, 17'h0_0C00, REF);
      xchk(FBP_OP_DREAD, 17'h0_0800, OK_PAT);
      xchk(FBP_OP_ERASE, 17'h0_1000, OK_ONES);
   endtask
   task automatic exec_only_unit;
      set_prot(FBP_PROT_EXEC_ONLY);
      xchk(FBP_OP_FETCH, 17'h0_0BFC, OK_ONES);
      xchk(FBP_OP_DREAD, 17'h0_0800, REF);
      xchk(FBP_OP_DBGREAD, 17'h0_0C00, REF);
      xchk(FBP_OP_PROGRAM, 17'h0_0C00, REF);
      xchk(FBP_OP_ERASE, 17'h0_0800, REF);
      xchk(FBP_OP_DREAD, 17'h0_1000, OK_ONES);
   endtask
   initial begin
      repeat (5) @(negedge clock);
      reset = 1'b0;
      erase_and_program();
      read_only_unit();
      exec_only_unit();
      report_and_stop();
   end
   // Three erases of about 260 cycles plus short traffic stay well inside this span
   initial begin
      #20_000;
      err_count++;
      report_and_stop();
   end
endmodule // flash_block_protection_bench
